// File: pfm_pin_mux.sv
// Pin function multiplexer with AXI4-Lite configuration registers
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "pfm_map.svh"

// Notes on behaviour
// R1: Software enables each alternate on one pin
// R2: Straps preset selections after power-up
// R3: Pin 1: GPIO, fan drive, chassis lock
// R4: Pin 25: GPIO or blink indicator
// R5: Pin 27: GPIO or ring wake input
// R6: Pin 69: GPIO, floppy motor, IR select
// R7: Pin 71: GPIO, drive select, IR select
// R8: Parallel IRQ bit forces pins 117-127
// R9: Pins 117-124: GPIO or parallel IRQs
// R10: Pins 125-126: GPIO or parallel IRQs
// R11: Pin 127 decodes two bits with IRQ
// R12: Pin 128: GPIO, fan tach, unlock
// R13: Unlisted codes leave pin as GPIO
module pfm_pin_mux
    import pfm_pkg::*;
#(
    parameter int NPIN = `PFM_NPIN
)(
    // Clock, reset, enable
    input  wire logic            ref_clk,
    input  wire logic            rst_n,
    input  wire logic            clkEn,
    // Straps
    input  wire logic [1:0]      pinSelectStraps,
    // AXI4-Lite slave
    input  wire logic [`PFM_AW-1:0] s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic [`PFM_AW-1:0] s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    // Pads
    input  wire logic [NPIN-1:0] padIn,
    output logic [NPIN-1:0]      padOut,
    output logic [NPIN-1:0]      padOe,
    // General-purpose I/O core side
    input  wire logic [NPIN-1:0] gpioOut,
    input  wire logic [NPIN-1:0] gpioOe,
    output logic [NPIN-1:0]      gpioIn,
    // Alternate output sources
    input  wire logic            fanDriveOut2,
    input  wire logic            chassisLockOut,
    input  wire logic            blinkIndicatorOne,
    input  wire logic            floppyMotorOne,
    input  wire logic            floppyDriveSelectOne,
    input  wire logic            infraredSelectTwoOut,
    input  wire logic            infraredSelectTwoOe,
    input  wire logic            keyboardPortLine16Out,
    input  wire logic            keyboardPortLine16Oe,
    input  wire logic            infraredSelectOneOut,
    input  wire logic            infraredSelectOneOe,
    input  wire logic            chassisUnlockOut,
    // Alternate inputs toward the core
    output logic                 ringWakeIn,
    output logic                 infraredSelectTwoIn,
    output logic                 infraredSelectThreeIn,
    output logic [`PFM_NPIRQ-1:0] parallelIrqIn,
    output logic                 keyboardPortLine16In,
    output logic                 infraredSelectOneIn,
    output logic                 fanTachIn2
);

    // Configuration registers
    logic [`PFM_CFG_W-1:0] cfgOne_ff;
    logic [`PFM_CFG_W-1:0] cfgTwo_ff;
    logic [`PFM_CFG_W-1:0] cfgFour_ff;
    logic [`PFM_CFG_W-1:0] cfgFive_ff;
    logic [`PFM_CFG_W-1:0] cfgA_ff;
    logic                  strapDone_ff;   // Straps taken once
    // Bus state
    logic [`PFM_AW-1:0]    awAddr_ff;
    logic                  awFull_ff;
    logic [31:0]           wData_ff;
    logic                  wStrb_ff;       // Lane 0 only: fields are 8 bits
    logic                  wFull_ff;
    logic                  bValid_ff;
    logic [1:0]            bResp_ff;
    logic                  rValid_ff;
    logic [31:0]           rData_ff;
    logic [1:0]            rResp_ff;
    // Selection per pin
    pfm_sel_e              pinSel [NPIN];
    logic [NPIN-1:0]       altOut;
    logic [NPIN-1:0]       altOe;
    logic [2*NPIN-1:0]     statusBits;
    logic                  pirqSel;
    // Registered pad side and core inputs
    logic [NPIN-1:0]       padOut_ff;
    logic [NPIN-1:0]       padOe_ff;
    logic [NPIN-1:0]       gpioIn_ff;
    logic                  ringWake_ff;
    logic                  irSelTwoIn_ff;
    logic                  irSelThreeIn_ff;
    logic [`PFM_NPIRQ-1:0] pirqIn_ff;
    logic                  kbdLineIn_ff;
    logic                  irSelOneIn_ff;
    logic                  fanTach_ff;

    // Field decode
    function automatic logic isCode(input logic [1:0] fld, input logic [1:0] code);
        isCode = (fld == code);
    endfunction : isCode

    assign pirqSel = cfgOne_ff[`PFM_ONE_PIRQ];

    // Strap preset once after reset, ahead of any write, then writes
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfgOne_ff    <= `PFM_CFG_RST;
            cfgTwo_ff    <= `PFM_CFG_RST;
            cfgFour_ff   <= `PFM_CFG_RST;
            cfgFive_ff   <= `PFM_CFG_RST;
            cfgA_ff      <= `PFM_CFG_RST;
            strapDone_ff <= 1'b0;
        end
        else if (clkEn)
        begin
            if (!strapDone_ff)
            begin
                // Straps
                cfgOne_ff[`PFM_ONE_PIRQ] <= pinSelectStraps[`PFM_STRAP_PIRQ]; // R2
                cfgTwo_ff[`PFM_TWO_P1] <= pinSelectStraps[`PFM_STRAP_FAN] ?
                                          `PFM_C01 : 2'h0; // R2
                strapDone_ff <= 1'b1;
            end
            else if (awFull_ff && wFull_ff && wStrb_ff)
            begin
                // Unmapped writes are dropped
                case (awAddr_ff)
                    `PFM_A_ONE:  cfgOne_ff  <= wData_ff[`PFM_CFG_W-1:0];
                    `PFM_A_TWO:  cfgTwo_ff  <= wData_ff[`PFM_CFG_W-1:0];
                    `PFM_A_FOUR: cfgFour_ff <= wData_ff[`PFM_CFG_W-1:0];
                    `PFM_A_FIVE: cfgFive_ff <= wData_ff[`PFM_CFG_W-1:0];
                    `PFM_A_CFGA: cfgA_ff    <= wData_ff[`PFM_CFG_W-1:0];
                    default:     ;
                endcase
            end
        end
    end

    // Write channel: aw and w in either order, answer one cycle later
    assign s_axi_awready = !awFull_ff && !bValid_ff;
    assign s_axi_wready  = !wFull_ff && !bValid_ff;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            awAddr_ff <= '0;
            awFull_ff <= 1'b0;
            wData_ff  <= '0;
            wStrb_ff  <= 1'b0;
            wFull_ff  <= 1'b0;
            bValid_ff <= 1'b0;
            bResp_ff  <= `PFM_OKAY;
        end
        else if (clkEn)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awAddr_ff <= s_axi_awaddr;
                awFull_ff <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb[0];
                wFull_ff <= 1'b1;
            end
            if (awFull_ff && wFull_ff)
            begin
                // Status words are read-only: a write there is ignored
                awFull_ff <= 1'b0;
                wFull_ff  <= 1'b0;
                bValid_ff <= 1'b1;
                bResp_ff  <= (awAddr_ff > `PFM_A_STHI) ||
                             (awAddr_ff[1:0] != 2'h0) ? `PFM_SLVERR : `PFM_OKAY;
            end
            else if (bValid_ff && s_axi_bready)
            begin
                bValid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bValid_ff;
    assign s_axi_bresp  = bResp_ff;

    // Read channel: data one cycle after ar
    assign s_axi_arready = !rValid_ff;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rValid_ff <= 1'b0;
            rData_ff  <= '0;
            rResp_ff  <= `PFM_OKAY;
        end
        else if (clkEn)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                rValid_ff <= 1'b1;
                rResp_ff  <= `PFM_OKAY;
                rData_ff  <= '0;
                case (s_axi_araddr)
                    `PFM_A_ONE:  rData_ff[`PFM_CFG_W-1:0] <= cfgOne_ff;
                    `PFM_A_TWO:  rData_ff[`PFM_CFG_W-1:0] <= cfgTwo_ff;
                    `PFM_A_FOUR: rData_ff[`PFM_CFG_W-1:0] <= cfgFour_ff;
                    `PFM_A_FIVE: rData_ff[`PFM_CFG_W-1:0] <= cfgFive_ff;
                    `PFM_A_CFGA: rData_ff[`PFM_CFG_W-1:0] <= cfgA_ff;
                    // Live selection, two bits per pin
                    `PFM_A_STLO: rData_ff <= statusBits[`PFM_ST_LO];
                    `PFM_A_STHI: rData_ff[2*NPIN-33:0] <= statusBits[2*NPIN-1:32];
                    default:     rResp_ff <= `PFM_SLVERR;
                endcase
            end
            else if (rValid_ff && s_axi_rready)
            begin
                rValid_ff <= 1'b0;
            end
        end
    end

    assign s_axi_rvalid = rValid_ff;
    assign s_axi_rdata  = rData_ff;
    assign s_axi_rresp  = rResp_ff;

    // Selection decode; unmatched codes keep GPIO; sharing is software's duty
    always_comb
    begin
        for (int k = 0; k < NPIN; k++)
        begin
            pinSel[k] = SEL_GPIO; // R13
        end
        altOut = '0;
        altOe  = '0;
        // Pin 1
        if (isCode(cfgTwo_ff[`PFM_TWO_P1], `PFM_C01))
        begin
            pinSel[`PFM_P1] = SEL_ALT1; // R3
            altOut[`PFM_P1] = fanDriveOut2;
            altOe[`PFM_P1]  = 1'b1;
        end
        else if (isCode(cfgTwo_ff[`PFM_TWO_P1], `PFM_C10))
        begin
            pinSel[`PFM_P1] = SEL_ALT2; // R3
            altOut[`PFM_P1] = chassisLockOut;
            altOe[`PFM_P1]  = 1'b1;
        end
        // Pin 25
        if (isCode(cfgA_ff[`PFM_CA_P25], `PFM_C01))
        begin
            pinSel[`PFM_P25] = SEL_ALT1; // R4
            altOut[`PFM_P25] = blinkIndicatorOne;
            altOe[`PFM_P25]  = 1'b1;
        end
        // Pin 27, input only
        if (isCode(cfgA_ff[`PFM_CA_P27], `PFM_C01))
        begin
            pinSel[`PFM_P27] = SEL_ALT1; // R5
        end
        // Pin 69
        if (isCode(cfgFour_ff[`PFM_FR_P69], `PFM_C01))
        begin
            pinSel[`PFM_P69] = SEL_ALT1; // R6
            altOut[`PFM_P69] = floppyMotorOne;
            altOe[`PFM_P69]  = 1'b1;
        end
        else if (isCode(cfgFour_ff[`PFM_FR_P69], `PFM_C10))
        begin
            pinSel[`PFM_P69] = SEL_ALT2; // R6
            altOut[`PFM_P69] = infraredSelectTwoOut;
            altOe[`PFM_P69]  = infraredSelectTwoOe;
        end
        // Pin 71
        if (isCode(cfgFour_ff[`PFM_FR_P71], `PFM_C01))
        begin
            pinSel[`PFM_P71] = SEL_ALT1; // R7
            altOut[`PFM_P71] = floppyDriveSelectOne;
            altOe[`PFM_P71]  = 1'b1;
        end
        else if (isCode(cfgFour_ff[`PFM_FR_P71], `PFM_C10))
        begin
            pinSel[`PFM_P71] = SEL_ALT2; // R7
        end
        // Pins 117-126
        for (int k = `PFM_P117; k <= `PFM_P126; k++)
        begin
            if (pirqSel)
            begin
                pinSel[k] = SEL_PIRQ; // R9 R10
            end
        end
        // Pin 127: the IRQ select outranks both field bits
        if (pirqSel)
        begin
            pinSel[`PFM_P127] = SEL_PIRQ; // R8 R11
        end
        else if (isCode(cfgFour_ff[`PFM_FR_P127], `PFM_C01))
        begin
            pinSel[`PFM_P127] = SEL_ALT1; // R11
            altOut[`PFM_P127] = keyboardPortLine16Out;
            altOe[`PFM_P127]  = keyboardPortLine16Oe;
        end
        else if (isCode(cfgFour_ff[`PFM_FR_P127], `PFM_C10))
        begin
            pinSel[`PFM_P127] = SEL_ALT2; // R11
            altOut[`PFM_P127] = infraredSelectOneOut;
            altOe[`PFM_P127]  = infraredSelectOneOe;
        end
        // Pin 128
        if (isCode(cfgFive_ff[`PFM_FV_P128], `PFM_C10))
        begin
            pinSel[`PFM_P128] = SEL_ALT1; // R12
        end
        else if (isCode(cfgFive_ff[`PFM_FV_P128], `PFM_C11))
        begin
            pinSel[`PFM_P128] = SEL_ALT2; // R12
            altOut[`PFM_P128] = chassisUnlockOut;
            altOe[`PFM_P128]  = 1'b1;
        end
    end

    // Per-pin pad driver
    for (genvar i = 0; i < NPIN; i++)
    begin : g_pin
        assign statusBits[2*i+1:2*i] = pinSel[i];

        always_ff @(posedge ref_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                padOut_ff[i] <= 1'b0;
                padOe_ff[i]  <= 1'b0;
                gpioIn_ff[i] <= 1'b0;
            end
            else if (clkEn)
            begin
                // A pin lent to an alternate reads as zero on GPIO
                if (pinSel[i] == SEL_GPIO)
                begin
                    padOut_ff[i] <= gpioOut[i]; // R13
                    padOe_ff[i]  <= gpioOe[i];
                    gpioIn_ff[i] <= padIn[i];
                end
                else
                begin
                    padOut_ff[i] <= altOut[i];
                    padOe_ff[i]  <= altOe[i];
                    gpioIn_ff[i] <= 1'b0;
                end
            end
        end
    end

    // Alternate inputs: inactive low while their pin is elsewhere
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ringWake_ff     <= 1'b0;
            irSelTwoIn_ff   <= 1'b0;
            irSelThreeIn_ff <= 1'b0;
            pirqIn_ff       <= '0;
            kbdLineIn_ff    <= 1'b0;
            irSelOneIn_ff   <= 1'b0;
            fanTach_ff      <= 1'b0;
        end
        else if (clkEn)
        begin
            ringWake_ff     <= (pinSel[`PFM_P27] == SEL_ALT1) && padIn[`PFM_P27]; // R5
            irSelTwoIn_ff   <= (pinSel[`PFM_P69] == SEL_ALT2) && padIn[`PFM_P69]; // R6
            irSelThreeIn_ff <= (pinSel[`PFM_P71] == SEL_ALT2) && padIn[`PFM_P71]; // R7
            pirqIn_ff       <= pirqSel ? padIn[`PFM_P127:`PFM_P117] : '0; // R8
            kbdLineIn_ff    <= (pinSel[`PFM_P127] == SEL_ALT1) && padIn[`PFM_P127]; // R11
            irSelOneIn_ff   <= (pinSel[`PFM_P127] == SEL_ALT2) && padIn[`PFM_P127]; // R11
            fanTach_ff      <= (pinSel[`PFM_P128] == SEL_ALT1) && padIn[`PFM_P128]; // R12
        end
    end

    assign padOut                = padOut_ff;
    assign padOe                 = padOe_ff;
    assign gpioIn                = gpioIn_ff;
    assign ringWakeIn            = ringWake_ff;
    assign infraredSelectTwoIn   = irSelTwoIn_ff;
    assign infraredSelectThreeIn = irSelThreeIn_ff;
    assign parallelIrqIn         = pirqIn_ff;
    assign keyboardPortLine16In  = kbdLineIn_ff;
    assign infraredSelectOneIn   = irSelOneIn_ff;
    assign fanTachIn2            = fanTach_ff;

    // Checks on the selection paths
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence s_strapEdge;
        clkEn && !strapDone_ff;
    endsequence
    property p_r2;
        s_strapEdge |=> strapDone_ff &&
            cfgOne_ff[`PFM_ONE_PIRQ] == $past(pinSelectStraps[`PFM_STRAP_PIRQ]);
    endproperty
    a_r2: assert property (p_r2) else $error("straps not taken"); // R2

    property p_r3;
        clkEn && strapDone_ff && cfgTwo_ff[`PFM_TWO_P1] == `PFM_C10
            |=> padOe[`PFM_P1] && padOut[`PFM_P1] == $past(chassisLockOut);
    endproperty
    a_r3: assert property (p_r3) else $error("pin 1 lock"); // R3

    property p_r4;
        clkEn && cfgA_ff[`PFM_CA_P25] == `PFM_C01
            |=> padOut[`PFM_P25] == $past(blinkIndicatorOne);
    endproperty
    a_r4: assert property (p_r4) else $error("pin 25 blink"); // R4

    property p_r5;
        clkEn && cfgA_ff[`PFM_CA_P27] != `PFM_C01 |=> !ringWakeIn;
    endproperty
    a_r5: assert property (p_r5) else $error("ring input leaks"); // R5

    property p_r6;
        clkEn && cfgFour_ff[`PFM_FR_P69] == `PFM_C01
            |=> padOe[`PFM_P69] && padOut[`PFM_P69] == $past(floppyMotorOne);
    endproperty
    a_r6: assert property (p_r6) else $error("pin 69 motor"); // R6

    property p_r7;
        clkEn && cfgFour_ff[`PFM_FR_P71] == `PFM_C10
            |=> !padOe[`PFM_P71] && infraredSelectThreeIn == $past(padIn[`PFM_P71]);
    endproperty
    a_r7: assert property (p_r7) else $error("pin 71 input"); // R7

    property p_r8;
        clkEn && pirqSel |=> padOe[`PFM_P127:`PFM_P117] == '0 &&
            parallelIrqIn == $past(padIn[`PFM_P127:`PFM_P117]) && gpioIn[`PFM_P127] == 1'b0;
    endproperty
    a_r8: assert property (p_r8) else $error("irq override lost"); // R8

    property p_r12;
        clkEn && cfgFive_ff[`PFM_FV_P128] == `PFM_C11
            |=> padOut[`PFM_P128] == $past(chassisUnlockOut) && !fanTachIn2;
    endproperty
    a_r12: assert property (p_r12) else $error("pin 128 unlock wrong"); // R12

    property p_r13;
        clkEn && cfgTwo_ff[`PFM_TWO_P1] == `PFM_C11
            |=> padOut[`PFM_P1] == $past(gpioOut[`PFM_P1]) &&
                padOe[`PFM_P1] == $past(gpioOe[`PFM_P1]);
    endproperty
    a_r13: assert property (p_r13) else $error("unlisted code not GPIO"); // R13

endmodule : pfm_pin_mux

// File: pfm_map.svh
// Offsets, field positions, codes and reset values of the pin multiplexer
`ifndef PFM_MAP_SVH
`define PFM_MAP_SVH
// Pin slots on the pad vectors
`define PFM_NPIN     17
`define PFM_P1       0
`define PFM_P25      1
`define PFM_P27      2
`define PFM_P69      3
`define PFM_P71      4
`define PFM_P117     5
`define PFM_P126     14
`define PFM_P127     15
`define PFM_P128     16
`define PFM_NPIRQ    11
// Register byte addresses
`define PFM_AW       5
`define PFM_A_ONE    5'h00
`define PFM_A_TWO    5'h04
`define PFM_A_FOUR   5'h08
`define PFM_A_FIVE   5'h0c
`define PFM_A_CFGA   5'h10
`define PFM_A_STLO   5'h14
`define PFM_A_STHI   5'h18
// Field positions
`define PFM_CFG_W    8
`define PFM_ONE_PIRQ 6
`define PFM_TWO_P1   1:0
`define PFM_CA_P25   2:1
`define PFM_CA_P27   5:4
`define PFM_FR_P69   1:0
`define PFM_FR_P71   3:2
`define PFM_FR_P127  7:6
`define PFM_FV_P128  1:0
`define PFM_ST_LO    31:0
`define PFM_STRAP_PIRQ 0
`define PFM_STRAP_FAN  1
// Field codes, reset value, bus answers
`define PFM_C01      2'h1
`define PFM_C10      2'h2
`define PFM_C11      2'h3
`define PFM_CFG_RST  8'h00
`define PFM_OKAY     2'h0
`define PFM_SLVERR   2'h2
`endif

// File: pfm_pkg.sv
// Types shared by the pin multiplexer
package pfm_pkg;
    // Function carried by one pin, also reported in the status words
    typedef enum logic [1:0] {
        SEL_GPIO,
        SEL_ALT1,
        SEL_ALT2,
        SEL_PIRQ
    } pfm_sel_e;
endpackage : pfm_pkg

// File: pfm_board.sv
// Board model standing on the far side of the multiplexed pins
`timescale 1ns/1ps
module pfm_board #(
    parameter int NPIN = 17
)(
    // Device side of each pin
    input  wire logic [NPIN-1:0] padOut,
    input  wire logic [NPIN-1:0] padOe,
    // Board drive levels
    input  wire logic [NPIN-1:0] boardDrive,
    // Resolved level
    output logic      [NPIN-1:0] padIn
);
    // Board yields where the device drives
    assign padIn = (padOe & padOut) | (~padOe & boardDrive);
endmodule : pfm_board

// File: test_pin_function_multiplexer.sv
// Self-checking bench for the pin function multiplexer
`timescale 1ns/1ps
`include "pfm_map.svh"
module test_pin_function_multiplexer;
    import pfm_pkg::*;
    localparam int N = `PFM_NPIN;
    // Clock, reset, straps
    logic         ref_clk, rst_n, clkEn;
    logic [1:0]   straps;
    // Register bus
    logic [4:0]   s_axi_awaddr, s_axi_araddr;
    logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic         s_axi_rvalid, s_axi_rready;
    logic [31:0]  s_axi_wdata, s_axi_rdata;
    logic [3:0]   s_axi_wstrb;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    // Pads and cores
    logic [N-1:0] padIn, padOut, padOe, gpioOut, gpioOe, gpioIn, board;
    logic [11:0]  alt;
    logic         ringWakeIn, ir2In, ir3In, kbIn, ir1In, fanTachIn2;
    logic [10:0]  parallelIrqIn;
    // Expected state
    logic [7:0]   c1, c2, c4, c5, cA;
    logic [N-1:0] eOe, eOut, gMask, lvl;
    int           num_errors, checks_done;

    // Device under test
    pfm_pin_mux #(.NPIN(N)) uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .pinSelectStraps(straps),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .gpioOut(gpioOut), .gpioOe(gpioOe), .gpioIn(gpioIn),
        .fanDriveOut2(alt[0]), .chassisLockOut(alt[1]), .blinkIndicatorOne(alt[2]),
        .floppyMotorOne(alt[3]), .floppyDriveSelectOne(alt[4]),
        .infraredSelectTwoOut(alt[5]), .infraredSelectTwoOe(alt[6]),
        .keyboardPortLine16Out(alt[7]), .keyboardPortLine16Oe(alt[8]),
        .infraredSelectOneOut(alt[9]), .infraredSelectOneOe(alt[10]), .chassisUnlockOut(alt[11]),
        .ringWakeIn(ringWakeIn), .infraredSelectTwoIn(ir2In), .infraredSelectThreeIn(ir3In),
        .parallelIrqIn(parallelIrqIn), .keyboardPortLine16In(kbIn),
        .infraredSelectOneIn(ir1In), .fanTachIn2(fanTachIn2)
    );

    // Board partner on the pads
    pfm_board #(.NPIN(N)) board_i (.padOut(padOut), .padOe(padOe), .boardDrive(board), .padIn(padIn));

    // Clock at 25 MHz
    initial
    begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Compare
    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    // Expected drive of one pin
    function automatic void put(int i, logic o, logic d);
        eOe[i]  = o;
        eOut[i] = o & d;
    endfunction : put

    // GPIO pin
    function automatic void gp(int i);
        put(i, gpioOe[i], gpioOut[i]);
        gMask[i] = 1'b1;
    endfunction : gp

    // Expected pin functions
    function automatic void calc();
        eOe = '0;
        eOut = '0;
        gMask = '0;
        case (c2[1:0])
            2'h1: put(0, 1'b1, alt[0]);
            2'h2: put(0, 1'b1, alt[1]);
            default: gp(0);
        endcase
        if (cA[2:1] == 2'h1) put(1, 1'b1, alt[2]); else gp(1);
        if (cA[5:4] == 2'h1) put(2, 1'b0, 1'b0); else gp(2);
        case (c4[1:0])
            2'h1: put(3, 1'b1, alt[3]);
            2'h2: put(3, alt[6], alt[5]);
            default: gp(3);
        endcase
        case (c4[3:2])
            2'h1: put(4, 1'b1, alt[4]);
            2'h2: put(4, 1'b0, 1'b0);
            default: gp(4);
        endcase
        for (int i = 5; i < 15; i++)
            if (c1[6]) put(i, 1'b0, 1'b0); else gp(i);
        if (c1[6]) put(15, 1'b0, 1'b0);
        else if (c4[7:6] == 2'h1) put(15, alt[8], alt[7]);
        else if (c4[7:6] == 2'h2) put(15, alt[10], alt[9]);
        else gp(15);
        case (c5[1:0])
            2'h2: put(16, 1'b0, 1'b0);
            2'h3: put(16, 1'b1, alt[11]);
            default: gp(16);
        endcase
        lvl = (eOe & eOut) | (~eOe & board);
    endfunction : calc

    // One transfer; ready seen at the negedge stands at the next rising edge
    task automatic axi(bit wr, logic [4:0] a, logic [31:0] wd, output logic [31:0] d, output logic [1:0] r);
        bit aT, wT, dT;
        @(posedge ref_clk);
        s_axi_awaddr <= a; s_axi_awvalid <= wr; s_axi_wdata <= wd; s_axi_wvalid <= wr; s_axi_bready <= wr;
        s_axi_araddr <= a; s_axi_arvalid <= !wr; s_axi_rready <= !wr;
        do
        begin
            @(negedge ref_clk);
            aT = wr ? s_axi_awready : s_axi_arready;
            wT = s_axi_wready;
            dT = wr ? s_axi_bvalid : s_axi_rvalid;
            d = s_axi_rdata;
            r = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge ref_clk);
            if (aT) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            if (wT) s_axi_wvalid <= 1'b0;
            if (dT) {s_axi_bready, s_axi_rready} <= 2'b00;
        end while (!dT);
    endtask : axi

    // Read check; upper bits read zero
    task automatic rd_chk(logic [4:0] a, logic [7:0] v);
        logic [31:0] d;
        logic [1:0] r;
        axi(1'b0, a, 32'h0, d, r);
        check("rresp", r, `PFM_OKAY);
        check("rdata", d, {24'h0, v});
    endtask : rd_chk

    // Write with random upper bits, read back
    task automatic wr_rd(logic [4:0] a, logic [7:0] v);
        logic [31:0] d;
        logic [1:0] r;
        axi(1'b1, a, ($urandom() & 32'hffffff00) | v, d, r);
        check("bresp", r, `PFM_OKAY);
        rd_chk(a, v);
    endtask : wr_rd

    // Pin checks
    task automatic cmp_pins();
        calc();
        check("padOe", padOe, eOe);
        check("padOut", padOut & padOe, eOut);
        check("gpioIn", gpioIn, lvl & gMask);
        check("pirq", parallelIrqIn, c1[6] ? lvl[15:5] : 11'h0);
        check("ring", ringWakeIn, (cA[5:4] == 2'h1) ? lvl[2] : 1'b0);
        check("ir3", ir3In, (c4[3:2] == 2'h2) ? lvl[4] : 1'b0);
        check("tach", fanTachIn2, (c5[1:0] == 2'h2) ? lvl[16] : 1'b0);
        check("ir2", ir2In, (c4[1:0] == 2'h2) ? lvl[3] : 1'b0);
        check("kb", kbIn, (!c1[6] && c4[7:6] == 2'h1) ? lvl[15] : 1'b0);
        check("ir1", ir1In, (!c1[6] && c4[7:6] == 2'h2) ? lvl[15] : 1'b0);
    endtask : cmp_pins

    // Reset with straps
    task automatic do_reset(logic [1:0] s);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        straps <= s;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask : do_reset

    // Verdict and end of run
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        final_report();
    end

    // Main sequence
    initial
    begin
        logic [1:0] c;
        logic [1:0] r;
        logic [31:0] d;
        void'($urandom(32'h3ef6));
        rst_n = 1'b0; clkEn = 1'b1; straps = 2'b11;
        s_axi_awaddr = '0; s_axi_awvalid = 1'b0; s_axi_wdata = '0; s_axi_wstrb = 4'hf;
        s_axi_wvalid = 1'b0; s_axi_bready = 1'b0; s_axi_araddr = '0; s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0; gpioOut = '0; gpioOe = '0; board = '0; alt = '0;
        num_errors = 0; checks_done = 0;
        do_reset(2'b11);
        // Strap preset
        c1 = 8'h40; c2 = 8'h01; c4 = 8'h00; c5 = 8'h00; cA = 8'h00;
        rd_chk(`PFM_A_ONE, c1);
        rd_chk(`PFM_A_TWO, c2);
        cmp_pins();
        // Code sweeps, then random
        for (int k = 0; k < 44; k++)
        begin
            c = k[1:0];
            if (k < 4)
            begin
                c1 = {1'b0, c[0], 6'h0}; c2 = {6'h0, c}; c4 = {c, c, c, c};
                c5 = {6'h0, c}; cA = {2'h0, c, 1'b0, c, 1'b0};
            end
            else
            begin
                c1 = 8'($urandom()); c2 = 8'($urandom()); c4 = 8'($urandom());
                c5 = 8'($urandom()); cA = 8'($urandom());
            end
            // One pin per alternate
            @(posedge ref_clk);
            gpioOut <= N'($urandom()); gpioOe <= N'($urandom());
            board <= N'($urandom()); alt <= 12'($urandom());
            wr_rd(`PFM_A_ONE, c1);
            wr_rd(`PFM_A_TWO, c2);
            wr_rd(`PFM_A_FOUR, c4);
            wr_rd(`PFM_A_FIVE, c5);
            wr_rd(`PFM_A_CFGA, cA);
            repeat (3) @(negedge ref_clk);
            cmp_pins();
        end
        // Unmapped address
        axi(1'b1, 5'h1c, 32'h0000_00ff, d, r);
        check("bresp bad", r, `PFM_SLVERR);
        axi(1'b0, 5'h1c, 32'h0, d, r);
        check("rresp bad", r, `PFM_SLVERR);
        check("rdata bad", d, 32'h0);
        // Second reset with straps low
        do_reset(2'b00);
        rd_chk(`PFM_A_ONE, 8'h00);
        rd_chk(`PFM_A_TWO, 8'h00);
        final_report();
    end
endmodule : test_pin_function_multiplexer
